// ### hdl/fsr_pkg.sv
// constants for the floppy status and drive control register bank
package fsr_pkg;
  localparam logic [9:0] ADDR_STATUS_A = 10'h3f0;
  localparam logic [9:0] ADDR_STATUS_B = 10'h3f1;
  localparam logic [9:0] ADDR_DRIVE_OUT = 10'h3f2;
  localparam logic [9:0] ADDR_TAPE = 10'h3f3;
  localparam logic [7:0] DRIVE_OUT_RESET = 8'h00;
  localparam logic [1:0] TAPE_RESET = 2'h0;
  localparam int DOR_SEL_LO = 0;
  localparam int DOR_SEL_HI = 1;
  localparam int DOR_SOFT_RESET_ACTIVE_LOW = 2;
  localparam int DOR_DMA_IRQ_GATE_ENABLE = 3;
  localparam int DOR_MOT0 = 4;
  localparam int DOR_MOT1 = 5;
  localparam int SOFT_RESET_MIN_NS = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFT_RESET_MIN_CYC = (SOFT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    FSR_BASIC_AT,
    FSR_FULL_STATUS,
    FSR_LATCHED_STATUS
  } fsr_mode_type;
endpackage

// ### hdl/fsr_regs.sv
// floppy status, drive output and tape assignment registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - full mode A: write-protect, index, track0 inverted; head true; second-drive bit 1.
// - full mode A bit 5 shows live step output.
// - A bit 7 shows interrupt output in full and latched modes.
// - latched mode A: direction inverted, pins active high, head select inverted.
// - latched mode A bit 6 shows DMA request pin.
// - latched mode A bit 5 latches step, cleared by input-register read or resets.
// - basic mode reads of A and B leave data bus undriven.
// - full mode B bits 1:0 show motor outputs; hardware reset only.
// - full mode B bit 2 shows write gate.
// - full mode B bits 3,4 toggle on read/write data inactive edges.
// - full mode B bit 5 mirrors drive output bit 0.
// - full mode B bits 7:6 read 1.
// - latched mode B bits 0, 1, 7 read 1.
// - latched mode B bit 2 sets on write gate rise, clears on input read.
// - latched mode B bits 3,4 set on data inactive edges, not gated by write gate.
// - latched mode B bits 5,6 show drive selects active low.
// - drive output register resets to zero, ignores soft reset, always writable.
// - bit 2 low holds controller reset until written 1; other state kept except the step latch, which soft reset clears.
// - basic/latched: bit 3 enables DMA and interrupt pins, else ignored or floated.
// - full mode keeps DMA and interrupt pins enabled; bit 3 is still stored and read back.
// - bits 4,5 drive motor outputs active low; bits 7:6 read 0.
// - bits 1:0 pick one drive select, gated by its motor bit.
// - tape register holds 2 bits, upper bits float, soft reset ignored.
// - full mode A bit 0 shows direction, 1 means inward.
module fsr_regs (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] mode_in,
  input wire logic [9:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic dir_read_in,
  input wire logic step_in,
  input wire logic head_dir_in,
  input wire logic head_side_select_in,
  input wire logic write_gate_in,
  input wire logic write_data_in,
  input wire logic irq_core_in,
  input wire logic dma_req_core_in,
  input wire logic dma_ack_n_pin_in,
  input wire logic term_count_pin_in,
  input wire logic write_protect_n_pin_in,
  input wire logic index_pulse_in,
  input wire logic track_zero_in,
  input wire logic read_data_n_pin_in,
  output logic [7:0] rdata_out,
  output logic rdata_oe_n_out,
  output logic [1:0] tape_rdata_oe_n_out,
  output logic soft_reset_active_low_out,
  output logic drive_select_0_out,
  output logic drive_select_1_out,
  output logic motor_on_drive0_out,
  output logic motor_on_drive1_out,
  output logic floppy_irq_out,
  output logic floppy_irq_oe_n_out,
  output logic dma_req_out,
  output logic dma_req_oe_n_out,
  output logic dma_ack_gated_out,
  output logic term_count_gated_out
);
  // pins synchronised; core signals arrive on this clock
  logic [5:0] pin_meta_ff;
  logic [5:0] pin_sync_ff;
  logic [7:0] drive_output_control_ff;
  logic [1:0] tape_drive_assign_ff;
  logic step_latch_ff;
  logic write_gate_latch_ff;
  logic rdata_latch_ff;
  logic wdata_latch_ff;
  logic rdata_tog_ff;
  logic wdata_tog_ff;
  logic step_d_ff;
  logic write_gate_d_ff;
  logic rdata_d_ff;
  logic wdata_d_ff;
  logic [7:0] rdata_ff;
  logic rd_oe_n_ff;
  logic [1:0] tape_oe_n_ff;

  wire logic wp_n = pin_sync_ff[0];
  wire logic idx_n = pin_sync_ff[1];
  wire logic track_zero_in_n = pin_sync_ff[2];
  wire logic rd_n = pin_sync_ff[3];
  wire logic dack_n = pin_sync_ff[4];
  wire logic tc_pin = pin_sync_ff[5];
  wire logic full_mode = (mode_in == 2'(fsr_pkg::FSR_FULL_STATUS));
  wire logic latched_mode = (mode_in == 2'(fsr_pkg::FSR_LATCHED_STATUS));
  wire logic soft_rst = ~drive_output_control_ff[fsr_pkg::DOR_SOFT_RESET_ACTIVE_LOW];
  wire logic sel_a = (addr_in == fsr_pkg::ADDR_STATUS_A);
  wire logic sel_b = (addr_in == fsr_pkg::ADDR_STATUS_B);
  wire logic sel_dor = (addr_in == fsr_pkg::ADDR_DRIVE_OUT);
  wire logic sel_tdr = (addr_in == fsr_pkg::ADDR_TAPE);
  wire logic wr_dor = wr_in & sel_dor;
  wire logic wr_tdr = wr_in & sel_tdr;
  wire logic mot0 = drive_output_control_ff[fsr_pkg::DOR_MOT0];
  wire logic mot1 = drive_output_control_ff[fsr_pkg::DOR_MOT1];
  wire logic [1:0] dsel = drive_output_control_ff[1:0];
  wire logic ds0_act = (dsel == 2'h0) & mot0;
  wire logic ds1_act = (dsel == 2'h1) & mot1;
  wire logic dma_en = full_mode | drive_output_control_ff[fsr_pkg::DOR_DMA_IRQ_GATE_ENABLE];
  // inactive edge: data pins are active low, so rising pin level
  wire logic rd_inact_edge = rd_n & ~rdata_d_ff;
  wire logic wd_inact_edge = write_data_in & ~wdata_d_ff;
  wire logic step_rise = step_in & ~step_d_ff;
  wire logic write_gate_rise = write_gate_in & ~write_gate_d_ff;
  wire logic clr_latch = dir_read_in | soft_rst;
  wire logic [7:0] sra_full = {irq_core_in, 1'b1, step_in, track_zero_in_n, head_side_select_in, idx_n, wp_n,
                               head_dir_in};
  wire logic [7:0] sra_latch = {irq_core_in, dma_req_core_in, step_latch_ff, ~track_zero_in_n,
                                ~head_side_select_in, ~idx_n, ~wp_n, ~head_dir_in};
  wire logic [7:0] srb_full = {2'h3, drive_output_control_ff[0], wdata_tog_ff, rdata_tog_ff, write_gate_in,
                               mot1, mot0};
  wire logic [7:0] srb_latch = {1'b1, ~ds1_act, ~ds0_act, wdata_latch_ff, rdata_latch_ff, write_gate_latch_ff,
                                2'h3};
  wire logic [7:0] sra_val = full_mode ? sra_full : sra_latch;
  wire logic [7:0] srb_val = full_mode ? srb_full : srb_latch;
  wire logic [7:0] dor_rd = {2'h0, drive_output_control_ff[5:0]};
  wire logic [7:0] tdr_rd = {6'h00, tape_drive_assign_ff};
  wire logic status_float = ~(full_mode | latched_mode) & (sel_a | sel_b);
  wire logic hit = sel_a | sel_b | sel_dor | sel_tdr;
  wire logic [7:0] nxt_rdata = sel_a ? sra_val : sel_b ? srb_val : sel_dor ? dor_rd : sel_tdr ? tdr_rd : 8'h00;
  wire logic nxt_rd_oe_n = ~(rd_in & hit & ~status_float);
  wire logic [1:0] nxt_tape_oe_n = {nxt_rd_oe_n | sel_tdr, nxt_rd_oe_n | ~sel_tdr};

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pin_meta_ff <= 6'h1f;
      pin_sync_ff <= 6'h1f;
    end else begin
      pin_meta_ff <= {term_count_pin_in, dma_ack_n_pin_in, read_data_n_pin_in, track_zero_in, index_pulse_in,
                      write_protect_n_pin_in};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // hardware reset only; soft reset leaves both registers alone
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      drive_output_control_ff <= fsr_pkg::DRIVE_OUT_RESET;
      tape_drive_assign_ff <= fsr_pkg::TAPE_RESET;
    end else begin
      if (wr_dor) begin
        drive_output_control_ff <= {2'h0, wdata_in[5:0]};
      end
      if (wr_tdr) begin
        tape_drive_assign_ff <= wdata_in[1:0];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      step_d_ff <= 1'b0;
      write_gate_d_ff <= 1'b0;
      rdata_d_ff <= 1'b1;
      wdata_d_ff <= 1'b1;
    end else begin
      step_d_ff <= step_in;
      write_gate_d_ff <= write_gate_in;
      rdata_d_ff <= rd_n;
      wdata_d_ff <= write_data_in;
    end
  end

  // set wins over clear
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      step_latch_ff <= 1'b0;
      write_gate_latch_ff <= 1'b0;
      rdata_latch_ff <= 1'b0;
      wdata_latch_ff <= 1'b0;
      rdata_tog_ff <= 1'b0;
      wdata_tog_ff <= 1'b0;
    end else begin
      step_latch_ff <= step_rise | (step_latch_ff & ~clr_latch);
      write_gate_latch_ff <= write_gate_rise | (write_gate_latch_ff & ~dir_read_in);
      rdata_latch_ff <= rd_inact_edge | (rdata_latch_ff & ~dir_read_in);
      wdata_latch_ff <= wd_inact_edge | (wdata_latch_ff & ~dir_read_in);
      rdata_tog_ff <= rdata_tog_ff ^ rd_inact_edge;
      wdata_tog_ff <= wdata_tog_ff ^ wd_inact_edge;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rdata_ff <= 8'h00;
      rd_oe_n_ff <= 1'b1;
      tape_oe_n_ff <= 2'h3;
    end else begin
      rdata_ff <= nxt_rdata;
      rd_oe_n_ff <= nxt_rd_oe_n;
      tape_oe_n_ff <= nxt_tape_oe_n;
    end
  end

  assign rdata_out = rdata_ff;
  assign rdata_oe_n_out = rd_oe_n_ff | ~tape_oe_n_ff[0];
  assign tape_rdata_oe_n_out = tape_oe_n_ff;
  assign soft_reset_active_low_out = ~soft_rst;
  assign drive_select_0_out = ~ds0_act;
  assign drive_select_1_out = ~ds1_act;
  assign motor_on_drive0_out = ~mot0;
  assign motor_on_drive1_out = ~mot1;
  assign floppy_irq_out = irq_core_in;
  assign floppy_irq_oe_n_out = ~dma_en;
  assign dma_req_out = dma_req_core_in;
  assign dma_req_oe_n_out = ~dma_en;
  assign dma_ack_gated_out = dma_en & ~dack_n;
  assign term_count_gated_out = dma_en & tc_pin;

  a_dor_hw_reset: assert property (@(posedge core_clk_in)
    !nrst_in
    |=> drive_output_control_ff == fsr_pkg::DRIVE_OUT_RESET)
    else $error("drive output not cleared");
  a_dor_write: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_dor
    |=> drive_output_control_ff[5:0] == $past(wdata_in[5:0]))
    else $error("drive output write lost");
  a_soft_reset_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (soft_rst && !wr_dor)
    |=> soft_rst)
    else $error("soft reset dropped");
  a_ds0_decode: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !drive_select_0_out
    |-> (drive_output_control_ff[1:0] == 2'h0 && mot0))
    else $error("bad select 0");
  a_step_latch: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    step_rise
    |=> step_latch_ff)
    else $error("step not latched");
  a_write_gate_clear: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (dir_read_in && !write_gate_rise)
    |=> !write_gate_latch_ff)
    else $error("write gate latch not cleared");
  a_rdata_toggle: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    rd_inact_edge
    |=> rdata_tog_ff != $past(rdata_tog_ff))
    else $error("read toggle missed");
  a_basic_float: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && status_float)
    |=> rdata_oe_n_out)
    else $error("status driven in basic mode");
  a_full_pins_on: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    full_mode
    |-> !dma_req_oe_n_out && !floppy_irq_oe_n_out)
    else $error("pins floated in full mode");
  a_srb_ones: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_b && full_mode)
    |=> rdata_out[7:6] == 2'h3)
    else $error("reserved bits not one");
  a_sra_second_drive_present_one: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_a && full_mode)
    |=> rdata_out[6])
    else $error("second drive bit not one");
  a_sra_full_pins: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_a && full_mode)
    |=> rdata_out[4:1] == $past({track_zero_in_n, head_side_select_in, idx_n, wp_n}))
    else $error("full status pins wrong");
  a_sra_step_live: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_a && full_mode)
    |=> rdata_out[5] == $past(step_in))
    else $error("live step bit wrong");
  a_sra_irq_bit: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_a && (full_mode || latched_mode))
    |=> rdata_out[7] == $past(irq_core_in))
    else $error("interrupt bit wrong");
  a_sra_dir_full: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_a && full_mode)
    |=> rdata_out[0] == $past(head_dir_in))
    else $error("direction bit wrong");
  a_sra_latch_pol: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_a && latched_mode)
    |=> rdata_out[4:0] == ~$past({track_zero_in_n, head_side_select_in, idx_n, wp_n, head_dir_in}))
    else $error("latched status polarity wrong");
  a_sra_drq_bit: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_a && latched_mode)
    |=> rdata_out[6] == $past(dma_req_core_in))
    else $error("dma request bit wrong");
  a_sra_step_ff: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_a && latched_mode)
    |=> rdata_out[5] == $past(step_latch_ff))
    else $error("latched step bit wrong");
  a_step_clear: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (clr_latch && !step_rise)
    |=> !step_latch_ff)
    else $error("step latch not cleared");
  a_srb_motor_bits: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_b && full_mode)
    |=> rdata_out[1:0] == $past({mot1, mot0}))
    else $error("motor bits wrong");
  a_srb_write_gate_bit: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_b && full_mode)
    |=> rdata_out[2] == $past(write_gate_in))
    else $error("write gate bit wrong");
  a_wdata_toggle: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wd_inact_edge
    |=> wdata_tog_ff != $past(wdata_tog_ff))
    else $error("write toggle missed");
  a_rdata_tog_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !rd_inact_edge
    |=> rdata_tog_ff == $past(rdata_tog_ff))
    else $error("read toggle moved");
  a_wdata_tog_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !wd_inact_edge
    |=> wdata_tog_ff == $past(wdata_tog_ff))
    else $error("write toggle moved");
  a_srb_dsel_bit: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_b && full_mode)
    |=> rdata_out[5] == $past(drive_output_control_ff[0]))
    else $error("drive select mirror wrong");
  a_srb_latch_ones: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_b && latched_mode)
    |=> rdata_out[7] && rdata_out[1:0] == 2'h3)
    else $error("unsupported select bits not one");
  a_write_gate_latch: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    write_gate_rise
    |=> write_gate_latch_ff)
    else $error("write gate not latched");
  a_rdata_latch: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    rd_inact_edge
    |=> rdata_latch_ff)
    else $error("read data not latched");
  a_wdata_latch: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wd_inact_edge
    |=> wdata_latch_ff)
    else $error("write data not latched");
  a_data_clear: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (dir_read_in && !rd_inact_edge && !wd_inact_edge)
    |=> !rdata_latch_ff && !wdata_latch_ff)
    else $error("data latches not cleared");
  a_srb_selects: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_b && latched_mode)
    |=> rdata_out[6:5] == $past({drive_select_1_out, drive_select_0_out}))
    else $error("select status bits wrong");
  a_dor_stable: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !wr_dor
    |=> drive_output_control_ff == $past(drive_output_control_ff))
    else $error("drive output changed unwritten");
  a_soft_reset_pin: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_dor
    |=> soft_reset_active_low_out == $past(wdata_in[2]))
    else $error("soft reset pin wrong");
  a_dma_gate_off: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (!full_mode && !drive_output_control_ff[fsr_pkg::DOR_DMA_IRQ_GATE_ENABLE])
    |-> dma_req_oe_n_out && floppy_irq_oe_n_out && !dma_ack_gated_out && !term_count_gated_out)
    else $error("dma pins not gated off");
  a_dma_gate_on: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    drive_output_control_ff[fsr_pkg::DOR_DMA_IRQ_GATE_ENABLE]
    |-> !dma_req_oe_n_out && !floppy_irq_oe_n_out)
    else $error("dma pins not enabled");
  a_full_reset_pins: assert property (@(posedge core_clk_in)
    (!nrst_in && full_mode)
    |-> !dma_req_oe_n_out && !floppy_irq_oe_n_out)
    else $error("pins floated during reset");
  a_dor_top_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_dor)
    |=> rdata_out[7:6] == 2'h0)
    else $error("unused motor bits not zero");
  a_motor_pins: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_dor
    |=> motor_on_drive0_out == !$past(wdata_in[4]) && motor_on_drive1_out == !$past(wdata_in[5]))
    else $error("motor pins wrong");
  a_ds1_decode: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !drive_select_1_out
    |-> (drive_output_control_ff[1:0] == 2'h1 && mot1))
    else $error("bad select 1");
  a_one_select: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !drive_select_0_out
    |-> drive_select_1_out)
    else $error("two drives selected");
  a_tape_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !wr_tdr
    |=> tape_drive_assign_ff == $past(tape_drive_assign_ff))
    else $error("tape register changed unwritten");
  a_tape_float: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (rd_in && sel_tdr)
    |=> tape_rdata_oe_n_out == 2'h2 && rdata_oe_n_out)
    else $error("tape upper bits driven");
  a_latch_hw_reset: assert property (@(posedge core_clk_in)
    !nrst_in
    |=> !step_latch_ff && !write_gate_latch_ff && !rdata_latch_ff && !wdata_latch_ff)
    else $error("latches not cleared by reset");
endmodule
`default_nettype wire

// ### testbench/fsr_drive_model.sv
// floppy drive model answering on the disk interface pins
`timescale 1ns/1ps
`default_nettype none
module fsr_drive_model (
  input wire logic core_clk_in,
  input wire logic drive_select_0_in,
  input wire logic motor_on_drive0_in,
  input wire logic pulse_in,
  input wire logic protect_in,
  output logic write_protect_n_out,
  output logic index_pulse_out,
  output logic track_zero_out,
  output logic read_data_n_out
);
  logic sel;
  logic [1:0] cnt_ff = 2'h0;
  // only a selected, spinning drive talks; released lines sit at the pull-up level
  assign sel = !drive_select_0_in && !motor_on_drive0_in;
  always_ff @(posedge core_clk_in) begin
    cnt_ff <= pulse_in ? 2'h2 : (cnt_ff != 2'h0 ? cnt_ff - 2'h1 : 2'h0);
  end
  assign write_protect_n_out = !(sel && protect_in);
  assign index_pulse_out = 1'b1;
  assign track_zero_out = 1'b1;
  assign read_data_n_out = !(sel && cnt_ff != 2'h0);
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the floppy status and drive control registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, dir_rd = 1'b0, step = 1'b0, hdir = 1'b0, side = 1'b0;
  logic wg = 1'b0, wd = 1'b1, irq = 1'b0, drq = 1'b0, dack_n = 1'b1, tc = 1'b0, pulse = 1'b0, prot = 1'b0;
  logic [1:0] mode = fsr_pkg::FSR_FULL_STATUS;
  logic [9:0] addr = 10'h3f0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [1:0] toe_n;
  logic oe_n, srst_n, ds0, ds1, m0, m1, fi, fi_oe_n, dq, dq_oe_n, wp_n, idx_n, trk_n, rdat_n, dack_g, tc_g;
  int errors = 0, n_tests = 0;
  logic [7:0] dv [5] = '{8'h18, 8'h1c, 8'h2d, 8'h3e, 8'hff};
  fsr_regs i_fsr_regs (.core_clk_in(clk), .nrst_in(nrst), .mode_in(mode), .addr_in(addr), .rd_in(rd),
    .wr_in(wr), .wdata_in(wdata), .dir_read_in(dir_rd), .step_in(step), .head_dir_in(hdir),
    .head_side_select_in(side), .write_gate_in(wg), .write_data_in(wd), .irq_core_in(irq),
    .dma_req_core_in(drq), .dma_ack_n_pin_in(dack_n), .term_count_pin_in(tc), .write_protect_n_pin_in(wp_n),
    .index_pulse_in(idx_n), .track_zero_in(trk_n), .read_data_n_pin_in(rdat_n), .rdata_out(rdata),
    .rdata_oe_n_out(oe_n), .tape_rdata_oe_n_out(toe_n), .soft_reset_active_low_out(srst_n),
    .drive_select_0_out(ds0), .drive_select_1_out(ds1), .motor_on_drive0_out(m0), .motor_on_drive1_out(m1),
    .floppy_irq_out(fi), .floppy_irq_oe_n_out(fi_oe_n), .dma_req_out(dq), .dma_req_oe_n_out(dq_oe_n),
    .dma_ack_gated_out(dack_g), .term_count_gated_out(tc_g));
  fsr_drive_model i_fsr_drive_model (.core_clk_in(clk), .drive_select_0_in(ds0), .motor_on_drive0_in(m0),
    .pulse_in(pulse), .protect_in(prot), .write_protect_n_out(wp_n), .index_pulse_out(idx_n),
    .track_zero_out(trk_n), .read_data_n_out(rdat_n));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // mask 0 means the read must be refused; masks other than 00 and ff skip the bus enable check
  task automatic rd_reg(input logic [9:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", e & m, rdata & m);
    if (m == 8'hff || m == 8'h00) chk("bus enable", {7'h0, m == 8'h00}, {7'h0, oe_n});
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    tick(8);
    nrst <= 1'b1;
    rd_reg(fsr_pkg::ADDR_DRIVE_OUT, fsr_pkg::DRIVE_OUT_RESET, 8'hff);
    chk("soft reset", 8'h00, {7'h0, srst_n});
    chk("select pins", 8'h03, {6'h0, ds1, ds0});
    for (int i = 0; i < 5; i++) begin
      wr_reg(fsr_pkg::ADDR_DRIVE_OUT, dv[i]);
      tick(1);
      chk("select pins", {6'h0, ~(dv[i][1:0] == 2'h1 && dv[i][5]), ~(dv[i][1:0] == 2'h0 && dv[i][4])},
          {6'h0, ds1, ds0});
      chk("motor pins", {6'h0, ~dv[i][5:4]}, {6'h0, m1, m0});
      chk("soft reset", {7'h0, dv[i][2]}, {7'h0, srst_n});
      rd_reg(fsr_pkg::ADDR_DRIVE_OUT, dv[i] & 8'h3f, 8'hff);
    end
    $display("test drive decode done");
    wr_reg(fsr_pkg::ADDR_DRIVE_OUT, 8'h15);
    tick(4);
    chk("irq enable", 8'h00, {7'h0, fi_oe_n});
    rd_reg(fsr_pkg::ADDR_STATUS_A, 8'h56, 8'hff);
    rd_reg(fsr_pkg::ADDR_STATUS_B, 8'he1, 8'hff);
    wr_reg(fsr_pkg::ADDR_DRIVE_OUT, 8'h1c);
    hdir <= 1'b1;
    side <= 1'b1;
    step <= 1'b1;
    irq <= 1'b1;
    wg <= 1'b1;
    tick(4);
    chk("irq pin", 8'h01, {7'h0, fi});
    rd_reg(fsr_pkg::ADDR_STATUS_A, 8'hff, 8'hff);
    rd_reg(fsr_pkg::ADDR_STATUS_B, 8'hc5, 8'hff);
    {hdir, side, step, irq, wg, pulse, wd} <= 7'h02;
    tick(1);
    pulse <= 1'b0;
    wd <= 1'b1;
    tick(8);
    rd_reg(fsr_pkg::ADDR_STATUS_B, 8'hd9, 8'hff);
    $display("test full status done");
    mode <= fsr_pkg::FSR_BASIC_AT;
    dack_n <= 1'b0;
    tc <= 1'b1;
    wr_reg(fsr_pkg::ADDR_DRIVE_OUT, 8'h14);
    tick(1);
    chk("irq and dma enable", 8'h03, {6'h0, fi_oe_n, dq_oe_n});
    chk("dma gating", 8'h00, {6'h0, dack_g, tc_g});
    wr_reg(fsr_pkg::ADDR_DRIVE_OUT, 8'h1c);
    tick(1);
    chk("irq and dma enable", 8'h00, {6'h0, fi_oe_n, dq_oe_n});
    chk("dma gating", 8'h03, {6'h0, dack_g, tc_g});
    dack_n <= 1'b1;
    tc <= 1'b0;
    rd_reg(fsr_pkg::ADDR_STATUS_A, 8'h00, 8'h00);
    rd_reg(fsr_pkg::ADDR_STATUS_B, 8'h00, 8'h00);
    rd_reg(10'h3f4, 8'h00, 8'h00);
    wr_reg(fsr_pkg::ADDR_TAPE, 8'hff);
    wr_reg(fsr_pkg::ADDR_DRIVE_OUT, 8'h18);
    rd_reg(fsr_pkg::ADDR_TAPE, 8'h03, 8'h03);
    chk("tape bus enable", 8'h02, {6'h0, toe_n});
    $display("test basic mode done");
    mode <= fsr_pkg::FSR_LATCHED_STATUS;
    wr_reg(fsr_pkg::ADDR_DRIVE_OUT, 8'h1c);
    dir_rd <= 1'b1;
    tick(1);
    dir_rd <= 1'b0;
    tick(4);
    rd_reg(fsr_pkg::ADDR_STATUS_A, 8'h09, 8'hff);
    rd_reg(fsr_pkg::ADDR_STATUS_B, 8'hc3, 8'hff);
    {step, drq, wg} <= 3'h7;
    tick(1);
    {step, wg, pulse, wd} <= 4'h2;
    tick(1);
    pulse <= 1'b0;
    wd <= 1'b1;
    tick(8);
    chk("dma request pin", 8'h01, {7'h0, dq});
    rd_reg(fsr_pkg::ADDR_STATUS_A, 8'h69, 8'hff);
    rd_reg(fsr_pkg::ADDR_STATUS_B, 8'hdf, 8'hff);
    dir_rd <= 1'b1;
    drq <= 1'b0;
    tick(1);
    dir_rd <= 1'b0;
    tick(4);
    rd_reg(fsr_pkg::ADDR_STATUS_A, 8'h09, 8'hff);
    rd_reg(fsr_pkg::ADDR_STATUS_B, 8'hc3, 8'hff);
    $display("test latched status done");
    test_done();
  end
endmodule
`default_nettype wire
